// ===== shared/adc_ctrl_pkg.sv
// Constants, types and field layout for the dual converter serial control block.
// Assumes a single system clock; every converter pin is sampled by the block itself.
// Operation
// R1: Capture serial configuration input on falling clock edges after the read strobe; 12 bits.
// R2: Host sends each configuration word most significant bit first, one bit per clock.
// R3: Configuration word holds all zeros after power-up until written.
// R4: Word from bit 11: channel, update pair, deep, nap, auto-nap, ref off, dual read, command.
// R5: Channel code 00, 01, 10, 11 selects the four documented input pairings.
// R6: Power-down, reference and dual-read settings change only when the update pair is 01.
// R7: Host never writes update pair value 10; reserved for factory test.
// R8: An updated power-down bit of one enters that power-down mode.
// R9: Reference-off bit of one turns the internal reference off.
// R10: Dual-read bit of one enables the special read in single-lane modes.
// R11: Command 001 makes next access a DAC write; 011 a DAC read; others idle.
// R12: Command 101 performs a software reset to default state.
// R13: New settings take effect on the rising edge of the twelfth clock.
// R14: DAC register ignores bits 11 and 10, holds the code below; resets to 3FF.
// R15: Host should avoid DAC codes giving outputs below half a volt.
// R16: Output data becomes valid from the third falling clock edge after the strobe.
// R17: Results are 12-bit two's complement, 7FF top, 800 bottom.
// R18: The same result may be read repeatedly until a new conversion trigger.
// R19: Channel-mode pin high advances channel after each conversion, ignoring select bits.
// R20: Lane-mode pin low gives one output per converter; high uses the first only.
// R21: Host may tie conversion trigger and read strobe together or drive them apart.
// R22: Power-on reset puts the device into its default mode.
// R23: Word after a 001 command: two ignored bits, then the ten-bit DAC code.
// R24: Read after a 011 command sends four zeros, DAC code, two zeros on first output.
// R25: Dual-lane manual frame is two zeros, 12-bit result MSB first, two zeros.
// R26: The twelve falling edges right after the strobe are the word's bit slots.
package adc_ctrl_pkg;

  localparam int unsigned CFG_W       = 12;
  localparam int unsigned RES_W       = 12;
  localparam int unsigned DAC_W       = 10;
  localparam int unsigned SLOT_W      = 16;
  localparam int unsigned FRAME_W     = 32;
  localparam int unsigned CNT_W       = 6;

  // Configuration word fields
  localparam int unsigned CHAN_HI     = 11;
  localparam int unsigned CHAN_LO     = 10;
  localparam int unsigned UPD_HI      = 9;
  localparam int unsigned UPD_LO      = 8;
  localparam int unsigned DEEP_BIT    = 7;
  localparam int unsigned NAP_BIT     = 6;
  localparam int unsigned ANAP_BIT    = 5;
  localparam int unsigned REFOFF_BIT  = 4;
  localparam int unsigned DUAL_BIT    = 3;
  localparam int unsigned CMD_HI      = 2;
  localparam int unsigned CMD_LO      = 0;

  localparam logic [1:0]       UPDATE_CODE   = 2'h1;
  localparam logic [2:0]       CMD_DAC_WRITE = 3'h1;
  localparam logic [2:0]       CMD_DAC_READ  = 3'h3;
  localparam logic [2:0]       CMD_SOFT_RST  = 3'h5;
  localparam logic [CFG_W-1:0] CFG_RESET     = 12'h000;
  localparam logic [DAC_W-1:0] DAC_RESET     = 10'h3FF;
  localparam logic [1:0]       CHAN_PAIR0    = 2'h0;
  localparam logic [1:0]       CHAN_PAIR1    = 2'h3;

  localparam logic [CNT_W-1:0] LAST_CFG_EDGE = 6'h0C;
  localparam logic [CNT_W-1:0] LEN_SHORT     = 6'h10;
  localparam logic [CNT_W-1:0] LEN_LONG      = 6'h20;

  typedef enum logic [1:0] {AUX_NONE, AUX_DAC_WRITE, AUX_DAC_READ} aux_type;
  typedef enum logic {FRAME_IDLE, FRAME_ACTIVE} frame_state_type;

  typedef struct packed {
    logic deep_sleep_en;
    logic nap_en;
    logic auto_nap_en;
    logic ref_off;
    logic dual_result_read;
  } feature_type;

  localparam feature_type FEATURE_RESET = '0;

endpackage : adc_ctrl_pkg

// ===== logic/dual_adc_serial_control.sv
// Serial configuration and result readout for a dual simultaneous-sampling converter.
// Assumes the converter clock, strobes and mode pins arrive asynchronously as pins,
// and the analog core hands back both results with a one-cycle done pulse on clk.
`timescale 1ns/1ps
`default_nettype none

module dual_adc_serial_control
  import adc_ctrl_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             adc_clock_pin,
  input  wire logic             read_strobe,
  input  wire logic             conversion_trigger,
  input  wire logic             serial_config_in,
  input  wire logic             auto_chan_pin,
  input  wire logic             single_lane_pin,
  input  wire logic [RES_W-1:0] result_a,
  input  wire logic [RES_W-1:0] result_b,
  input  wire logic             result_done,
  output logic                  conv_start,
  output logic      [1:0]       chan_select,
  output feature_type           features,
  output logic      [DAC_W-1:0] dac_code,
  output logic      [CFG_W-1:0] control_word,
  output logic                  serial_out_first,
  output logic                  serial_out_first_oe,
  output logic                  serial_out_second,
  output logic                  serial_out_second_oe
);

  localparam int unsigned PINS = 6;

  logic                   rst_meta_r;
  logic                   rst_n_r;
  logic [PINS-1:0]        pin_meta_r;
  logic [PINS-1:0]        pin_sync_r;
  logic                   clk_prev_r;
  logic                   trig_prev_r;
  logic                   ck_s;
  logic                   rd_s;
  logic                   trig_s;
  logic                   sdi_s;
  logic                   auto_s;
  logic                   single_s;
  logic                   ck_fall;
  logic                   ck_rise;
  logic                   trig_rise;

  frame_state_type        frame_state_r;
  logic [CNT_W-1:0]       edge_cnt_r;
  logic [CNT_W-1:0]       frame_len_r;
  logic                   frame_start;
  logic                   frame_edge;
  aux_type                aux_pend_r;
  aux_type                frame_aux_r;

  logic [CFG_W-1:0]       cfg_shift_r;
  logic                   apply_pend_r;
  logic                   apply;
  logic                   soft_rst;

  logic [CFG_W-1:0]       control_word_r;
  feature_type            features_r;
  logic [DAC_W-1:0]       dac_r;

  logic [RES_W-1:0]       res_a_r;
  logic [RES_W-1:0]       res_b_r;
  logic                   conv_chan_r;
  logic                   res_chan_r;
  logic                   auto_chan_r;
  logic                   ab_sel_r;
  logic                   conv_start_r;

  logic [FRAME_W-1:0]     shift_first_r;
  logic [SLOT_W-1:0]      shift_second_r;
  logic                   out_first_r;
  logic                   out_second_r;
  logic [FRAME_W-1:0]     first_nxt;
  logic [SLOT_W-1:0]      second_nxt;
  logic [CNT_W-1:0]       len_nxt;
  logic                   chan_ind;

  // Builds one sixteen-slot lane frame: two header slots, result, two trailing zeros
  function automatic logic [SLOT_W-1:0] slot_frame(input logic [1:0] head, input logic [RES_W-1:0] data);
    slot_frame = {head, data, 2'h0}; // [R25] [R16]
  endfunction : slot_frame

  // Reset release through two flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // Pin synchronisers
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end else begin
      pin_meta_r <= {single_lane_pin, auto_chan_pin, serial_config_in, conversion_trigger,
                     read_strobe, adc_clock_pin};
      pin_sync_r <= pin_meta_r;
    end
  end

  assign ck_s     = pin_sync_r[0];
  assign rd_s     = pin_sync_r[1];
  assign trig_s   = pin_sync_r[2];
  assign sdi_s    = pin_sync_r[3];
  assign auto_s   = pin_sync_r[4];
  assign single_s = pin_sync_r[5];

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      clk_prev_r  <= 1'b0;
      trig_prev_r <= 1'b0;
    end else begin
      clk_prev_r  <= ck_s;
      trig_prev_r <= trig_s;
    end
  end

  assign ck_fall   = clk_prev_r & ~ck_s;
  assign ck_rise   = ~clk_prev_r & ck_s;
  assign trig_rise = ~trig_prev_r & trig_s;

  // A strobe seen at a falling edge opens a frame; a new one may open on the edge after the last slot
  assign frame_start = ck_fall & rd_s &
                       ((frame_state_r == FRAME_IDLE) || (edge_cnt_r == frame_len_r)); // [R21]
  assign frame_edge  = ck_fall & (frame_state_r == FRAME_ACTIVE) & (edge_cnt_r != frame_len_r);

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      frame_state_r <= FRAME_IDLE;
      edge_cnt_r    <= '0;
      frame_len_r   <= LEN_SHORT;
    end else if (frame_start) begin
      frame_state_r <= FRAME_ACTIVE;
      edge_cnt_r    <= '0;
      frame_len_r   <= len_nxt;
    end else if (frame_edge) begin
      edge_cnt_r <= edge_cnt_r + 1'b1;
    end else if (ck_fall && (edge_cnt_r == frame_len_r)) begin
      frame_state_r <= FRAME_IDLE;
    end
  end

  // Word capture in the twelve falling-edge slots after the strobe
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cfg_shift_r  <= CFG_RESET;
      apply_pend_r <= 1'b0;
    end else begin
      if (frame_edge && (edge_cnt_r < LAST_CFG_EDGE)) begin
        cfg_shift_r <= {cfg_shift_r[CFG_W-2:0], sdi_s}; // [R1] [R26] [R2]
      end
      if (frame_edge && (edge_cnt_r == LAST_CFG_EDGE - 1'b1)) begin
        apply_pend_r <= 1'b1;
      end else if (ck_rise) begin
        apply_pend_r <= 1'b0;
      end
    end
  end

  // Settings land on the rising edge that ends the twelfth clock
  assign apply    = apply_pend_r & ck_rise; // [R13]
  assign soft_rst = apply & (frame_aux_r == AUX_NONE) &
                    (cfg_shift_r[CMD_HI:CMD_LO] == CMD_SOFT_RST); // [R12]

  // Configuration word; DAC access frames leave it untouched
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      control_word_r <= CFG_RESET; // [R3] [R22]
    end else if (soft_rst) begin
      control_word_r <= CFG_RESET; // [R12]
    end else if (apply && (frame_aux_r == AUX_NONE)) begin
      control_word_r <= cfg_shift_r; // [R4]
    end
  end

  // Feature settings
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      features_r <= FEATURE_RESET; // [R22]
    end else if (soft_rst) begin
      features_r <= FEATURE_RESET;
    end else if (apply && (frame_aux_r == AUX_NONE) &&
                 (cfg_shift_r[UPD_HI:UPD_LO] == UPDATE_CODE)) begin // [R6] [R7]
      features_r.deep_sleep_en    <= cfg_shift_r[DEEP_BIT];   // [R8]
      features_r.nap_en           <= cfg_shift_r[NAP_BIT];    // [R8]
      features_r.auto_nap_en      <= cfg_shift_r[ANAP_BIT];   // [R8]
      features_r.ref_off          <= cfg_shift_r[REFOFF_BIT]; // [R9]
      features_r.dual_result_read <= cfg_shift_r[DUAL_BIT];   // [R10]
    end
  end

  // Reference DAC register; upper two bits of the word are dropped
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      dac_r <= DAC_RESET; // [R14]
    end else if (soft_rst) begin
      dac_r <= DAC_RESET;
    end else if (apply && (frame_aux_r == AUX_DAC_WRITE)) begin
      dac_r <= cfg_shift_r[DAC_W-1:0]; // [R23] [R14] [R15]
    end
  end

  // Pending command for the next access and the kind of the running frame
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      aux_pend_r  <= AUX_NONE;
      frame_aux_r <= AUX_NONE;
    end else begin
      if (frame_start) begin
        frame_aux_r <= aux_pend_r;
      end
      if (frame_start) begin
        aux_pend_r <= AUX_NONE;
      end else if (soft_rst) begin
        aux_pend_r <= AUX_NONE;
      end else if (apply && (frame_aux_r == AUX_NONE)) begin
        unique case (cfg_shift_r[CMD_HI:CMD_LO])
          CMD_DAC_WRITE: aux_pend_r <= AUX_DAC_WRITE; // [R11]
          CMD_DAC_READ:  aux_pend_r <= AUX_DAC_READ;  // [R11]
          default:       aux_pend_r <= AUX_NONE;
        endcase
      end
    end
  end

  // Conversion start, channel steering and result hold
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      conv_start_r <= 1'b0;
      conv_chan_r  <= 1'b0;
    end else begin
      conv_start_r <= trig_rise;
      if (trig_rise) begin
        conv_chan_r <= chan_select[CHAN_HI-CHAN_LO];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      auto_chan_r <= 1'b0;
    end else if (soft_rst) begin
      auto_chan_r <= 1'b0;
    end else if (result_done && auto_s) begin
      auto_chan_r <= ~auto_chan_r; // [R19]
    end
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      res_a_r    <= '0;
      res_b_r    <= '0;
      res_chan_r <= 1'b0;
    end else if (result_done) begin
      res_a_r    <= result_a; // [R17] [R18]
      res_b_r    <= result_b;
      res_chan_r <= conv_chan_r;
    end
  end

  // Single-lane reads alternate between converters until a fresh result arrives
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ab_sel_r <= 1'b0;
    end else if (result_done) begin
      ab_sel_r <= 1'b0;
    end else if (frame_start && single_s && !features_r.dual_result_read &&
                 (aux_pend_r != AUX_DAC_READ)) begin
      ab_sel_r <= ~ab_sel_r; // [R20]
    end
  end

  assign chan_select = auto_s ? (auto_chan_r ? CHAN_PAIR1 : CHAN_PAIR0)
                              : control_word_r[CHAN_HI:CHAN_LO]; // [R5] [R19]
  assign chan_ind    = auto_s & res_chan_r;

  // Frame contents chosen at the strobe
  always_comb begin
    first_nxt  = '0;
    second_nxt = slot_frame({chan_ind, 1'b0}, res_b_r); // [R20]
    len_nxt    = LEN_SHORT;
    if (aux_pend_r == AUX_DAC_READ) begin
      first_nxt[FRAME_W-1 -: SLOT_W] = {4'h0, dac_r, 2'h0}; // [R24]
    end else if (single_s && features_r.dual_result_read) begin
      first_nxt = {slot_frame({chan_ind, 1'b0}, res_a_r),
                   slot_frame({chan_ind, 1'b1}, res_b_r)}; // [R10]
      len_nxt   = LEN_LONG;
    end else if (single_s) begin
      first_nxt[FRAME_W-1 -: SLOT_W] = slot_frame({chan_ind, ab_sel_r},
                                                  ab_sel_r ? res_b_r : res_a_r); // [R20]
    end else begin
      first_nxt[FRAME_W-1 -: SLOT_W] = slot_frame({chan_ind, 1'b0}, res_a_r); // [R25]
    end
  end

  // Output lanes: each falling edge drives the next slot, first data at the third edge
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      shift_first_r  <= '0;
      shift_second_r <= '0;
      out_first_r    <= 1'b0;
      out_second_r   <= 1'b0;
    end else begin
      if (frame_edge) begin
        out_first_r  <= shift_first_r[FRAME_W-1]; // [R16]
        out_second_r <= shift_second_r[SLOT_W-1];
      end else if (ck_fall) begin
        out_first_r  <= 1'b0;
        out_second_r <= 1'b0;
      end
      if (frame_start) begin
        shift_first_r  <= first_nxt;
        shift_second_r <= second_nxt;
      end else if (frame_edge) begin
        shift_first_r  <= {shift_first_r[FRAME_W-2:0], 1'b0};
        shift_second_r <= {shift_second_r[SLOT_W-2:0], 1'b0};
      end
    end
  end

  assign conv_start           = conv_start_r;
  assign features             = features_r;
  assign dac_code             = dac_r;
  assign control_word         = control_word_r;
  assign serial_out_first     = out_first_r;
  assign serial_out_first_oe  = rst_n_r;
  assign serial_out_second    = out_second_r;
  assign serial_out_second_oe = rst_n_r & ~single_s; // [R20]

endmodule : dual_adc_serial_control

`default_nettype wire

// ===== tb/adc_ctrl_chk.sv
// Port checker for the dual converter serial control block.
// Bound to the top module; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_chk
  import adc_ctrl_pkg::*;
(
  input wire logic             clk,
  input wire logic             reset_n,
  input wire logic             adc_clock_pin,
  input wire logic             read_strobe,
  input wire logic             conversion_trigger,
  input wire logic             auto_chan_pin,
  input wire logic             single_lane_pin,
  input wire logic             conv_start,
  input wire logic [1:0]       chan_select,
  input wire feature_type      features,
  input wire logic [DAC_W-1:0] dac_code,
  input wire logic [CFG_W-1:0] control_word,
  input wire logic             serial_out_first,
  input wire logic             serial_out_first_oe,
  input wire logic             serial_out_second,
  input wire logic             serial_out_second_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_idle;
    !read_strobe && !adc_clock_pin;
  endsequence
  sequence s_trig;
    $rose(conversion_trigger);
  endsequence

  AST_RESET_VALUES: assert property ($rose(reset_n) |-> dac_code == DAC_RESET && control_word == CFG_RESET)
    else $error("reset values wrong");
  AST_OE_FIRST: assert property (reset_n [*4] |-> serial_out_first_oe)
    else $error("first lane not enabled");
  AST_OE_SECOND: assert property ((reset_n && $stable(single_lane_pin)) [*5] |-> serial_out_second_oe == !single_lane_pin)
    else $error("second lane enable wrong");
  AST_CONV_START: assert property (s_trig |-> ##[2:3] conv_start)
    else $error("no conversion start");
  AST_CONV_PULSE: assert property (conv_start |=> !conv_start)
    else $error("conversion start too long");
  AST_FEAT_FOLLOW: assert property ($changed(features) |-> features == control_word[DEEP_BIT:DUAL_BIT])
    else $error("features differ from word");
  AST_FEAT_GATE: assert property ($changed(features) |->
    control_word[UPD_HI:UPD_LO] == UPDATE_CODE || control_word == CFG_RESET)
    else $error("features changed without update code");
  AST_CHAN_MANUAL: assert property (!auto_chan_pin [*4] |-> chan_select == control_word[CHAN_HI:CHAN_LO])
    else $error("manual channel wrong");
  AST_WORD_TIMING: assert property ($changed(control_word) |-> adc_clock_pin)
    else $error("word changed off rising clock");
  AST_DAC_TIMING: assert property ($changed(dac_code) |-> adc_clock_pin)
    else $error("dac changed off rising clock");
  AST_LANE_IDLE: assert property (s_idle [*8] |-> !serial_out_first && !serial_out_second)
    else $error("lane busy while idle");
endmodule : adc_ctrl_chk

bind dual_adc_serial_control adc_ctrl_chk chk (.clk, .reset_n, .adc_clock_pin, .read_strobe,
  .conversion_trigger, .auto_chan_pin, .single_lane_pin, .conv_start, .chan_select, .features,
  .dac_code, .control_word, .serial_out_first, .serial_out_first_oe, .serial_out_second,
  .serial_out_second_oe);
`default_nettype wire

// ===== tb/host_model.sv
// Host model: converter clock frames with read strobe and config word.
// Assumes clk at 100 MHz; converter clock stands low between frames.
`timescale 1ns/1ps
`default_nettype none
module host_model
  import adc_ctrl_pkg::*;
(
  input  wire logic clk,
  input  wire logic din_first,
  input  wire logic din_second,
  output logic      adc_clock_pin,
  output logic      read_strobe,
  output logic      serial_config_in
);
  logic [FRAME_W-1:0] lane_a;
  logic [FRAME_W-1:0] lane_b;

  initial begin
    adc_clock_pin = 1'b0;
    read_strobe = 1'b0;
    serial_config_in = 1'b0;
    lane_a = '0;
    lane_b = '0;
  end

  // Half period of 6 clk stays above what the pin synchroniser needs
  task automatic step();
    repeat (6) @(posedge clk);
    #1;
  endtask : step

  task automatic frame(input logic [CFG_W-1:0] word, input int slots);
    int k;
    read_strobe = 1'b1;
    adc_clock_pin = 1'b1;
    step();
    adc_clock_pin = 1'b0;
    step();
    read_strobe = 1'b0;
    for (k = 1; k <= slots; k++) begin
      // Word MSB first in slots 1 to 12, a toggling pattern after
      serial_config_in = (k <= CFG_W) ? word[CFG_W-k] : ~serial_config_in;
      adc_clock_pin = 1'b1;
      step();
      adc_clock_pin = 1'b0;
      step();
      lane_a = {lane_a[FRAME_W-2:0], din_first};
      lane_b = {lane_b[FRAME_W-2:0], din_second};
    end
    serial_config_in = ~serial_config_in;
  endtask : frame
endmodule : host_model
`default_nettype wire

// ===== tb/dual_adc_serial_control_test.sv
// Self-checking bench for the dual converter serial control block.
// Assumes the host model drives the clock, read strobe and config pins; the bench plays the analog core and drives the other pins.
`timescale 1ns/1ps
`default_nettype none
module dual_adc_serial_control_test import adc_ctrl_pkg::*;;
  logic             clk;
  logic             reset_n;
  logic             conversion_trigger;
  logic             auto_chan_pin;
  logic             single_lane_pin;
  logic             result_done;
  logic [RES_W-1:0] result_a;
  logic [RES_W-1:0] result_b;
  logic             adc_clock_pin;
  logic             read_strobe;
  logic             serial_config_in;
  logic             conv_start;
  logic [1:0]       chan_select;
  feature_type      features;
  logic [DAC_W-1:0] dac_code;
  logic [CFG_W-1:0] control_word;
  logic             serial_out_first;
  logic             serial_out_first_oe;
  logic             serial_out_second;
  logic             serial_out_second_oe;
  int               bad_count;
  int               check_count;

  dual_adc_serial_control dut (.clk, .reset_n, .adc_clock_pin, .read_strobe, .conversion_trigger,
    .serial_config_in, .auto_chan_pin, .single_lane_pin, .result_a, .result_b, .result_done,
    .conv_start, .chan_select, .features, .dac_code, .control_word, .serial_out_first,
    .serial_out_first_oe, .serial_out_second, .serial_out_second_oe);
  host_model host (.clk, .din_first(serial_out_first), .din_second(serial_out_second),
    .adc_clock_pin, .read_strobe, .serial_config_in);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Trigger a conversion, then hand both results back with a done pulse
  task automatic convert(input logic [RES_W-1:0] a, input logic [RES_W-1:0] b);
    int n;
    conversion_trigger = 1'b1;
    n = 0;
    while (conv_start !== 1'b1 && n < 10) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 10) begin
      bad_count++;
      $display("mismatch at %0t: no conversion start", $time);
      print_verdict();
    end else begin
      conversion_trigger = 1'b0;
      result_a = a;
      result_b = b;
      result_done = 1'b1;
      @(posedge clk);
      #1;
      result_done = 1'b0;
    end
  endtask : convert

  task automatic t_reset();
    check(32'(control_word), 32'h000);
    check(32'(dac_code), 32'h3FF);
    check(32'(features), 32'h00);
    $display("test reset done");
  endtask : t_reset

  task automatic t_config();
    int i;
    host.frame(12'h9F8, 16);
    check(32'(control_word), 32'h9F8);
    check(32'(features), 32'h1F);
    for (i = 0; i < 4; i++) begin
      host.frame({i[1:0], i[0] ? 2'b11 : 2'b00, 8'h00}, 16);
      check(32'(chan_select), 32'(i));
      check(32'(features), 32'h1F);
    end
    $display("test config done");
  endtask : t_config

  task automatic t_dac();
    logic [2:0] noop [5] = '{3'h0, 3'h2, 3'h4, 3'h6, 3'h7};
    host.frame(12'h101, 16);
    host.frame(12'hFAA, 16);
    check(32'(dac_code), 32'h3AA);
    foreach (noop[i]) begin
      host.frame({9'h000, noop[i]}, 16);
      host.frame(12'h0AA, 16);
      check(32'(dac_code), 32'h3AA);
    end
    host.frame(12'h103, 16);
    host.frame(12'h000, 16);
    check(32'(host.lane_a[15:0]), 32'h0EA8);
    $display("test dac done");
  endtask : t_dac

  task automatic t_results();
    convert(12'h7FF, 12'h800);
    repeat (2) begin
      host.frame(12'h000, 16);
      check(32'(host.lane_a[15:0]), 32'h1FFC);
      check(32'(host.lane_b[15:0]), 32'h2000);
    end
    convert(12'hFFF, 12'h000);
    host.frame(12'h000, 16);
    check(32'(host.lane_a[15:0]), 32'h3FFC);
    check(32'(host.lane_b[15:0]), 32'h0000);
    $display("test results done");
  endtask : t_results

  task automatic t_single();
    single_lane_pin = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check(32'(serial_out_second_oe), 32'h0);
    convert(12'h123, 12'h456);
    host.frame(12'h000, 16);
    check(32'(host.lane_a[15:0]), 32'h048C);
    host.frame(12'h000, 16);
    check(32'(host.lane_a[15:0]), 32'h5158);
    host.frame(12'h108, 16);
    check(32'(features), 32'h01);
    convert(12'h123, 12'h456);
    host.frame(12'h000, 32);
    check(host.lane_a, 32'h048C5158);
    $display("test single lane done");
  endtask : t_single

  task automatic t_auto();
    logic [1:0] c0;
    auto_chan_pin = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    c0 = chan_select;
    check(32'(c0 == CHAN_PAIR0 || c0 == CHAN_PAIR1), 32'h1);
    convert(12'h000, 12'h000);
    check(32'(chan_select), 32'(c0 ^ 2'h3));
    convert(12'h000, 12'h000);
    check(32'(chan_select), 32'(c0));
    $display("test auto channel done");
  endtask : t_auto

  task automatic t_soft();
    auto_chan_pin = 1'b0;
    single_lane_pin = 1'b0;
    host.frame(12'h9F8, 16);
    host.frame(12'h005, 16);
    check(32'(control_word), 32'h000);
    check(32'(features), 32'h00);
    check(32'(dac_code), 32'h3FF);
    $display("test soft reset done");
  endtask : t_soft

  initial begin
    reset_n = 1'b0;
    conversion_trigger = 1'b0;
    auto_chan_pin = 1'b0;
    single_lane_pin = 1'b0;
    result_done = 1'b0;
    result_a = '0;
    result_b = '0;
    bad_count = 0;
    check_count = 0;
    repeat (12) @(posedge clk);
    #1;
    reset_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    t_reset();
    t_config();
    t_dac();
    t_results();
    t_single();
    t_auto();
    t_soft();
    print_verdict();
  end
endmodule : dual_adc_serial_control_test
`default_nettype wire
